/* File: hw/phasing_pkg.sv */
package phasing_pkg;
    // ==========================================================
    // Clock and servo timing
    localparam int unsigned CLK_FREQ_HZ = 20000000;
    localparam int unsigned SERVO_FREQ_HZ = 2250;
    localparam int unsigned SERVO_DIV = CLK_FREQ_HZ / SERVO_FREQ_HZ;
    localparam int unsigned STEP_TIME_SCALE = 256;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_MAGNITUDE = 8'h00;
    localparam logic [7:0] OFS_DURATION = 8'h04;
    localparam logic [7:0] OFS_OFFSET = 8'h08;
    localparam logic [7:0] OFS_CONFIG = 8'h0c;
    localparam logic [7:0] OFS_COMMAND = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_PHASE_POS = 8'h18;

    // ==========================================================
    // Reset values
    localparam logic [15:0] RST_MAGNITUDE = 16'h0000;
    localparam logic [7:0] RST_DURATION = 8'h00;
    localparam logic [23:0] RST_OFFSET = 24'h000000;
    localparam logic [31:0] RST_CONFIG = 32'h00010000;

    // ==========================================================
    // Config register fields
    localparam int CFG_COMMUTATE = 0;
    localparam int CFG_SLIP = 1;
    localparam int CFG_MODE_LO = 2;
    localparam int CFG_CUR_LOOP = 4;
    localparam int CFG_PTR_LO = 8;
    localparam int CFG_CCC_LO = 16;

    // Command register bits
    localparam int CMD_PHASE_START = 0;
    localparam int CMD_REF_LOAD = 1;
    localparam int CMD_INIT_DONE = 2;

    // ==========================================================
    // Two-guess angles in 1/256 of a commutation cycle
    localparam logic [7:0] GUESS_ANGLE_A = 8'h00;
    localparam logic [7:0] GUESS_ANGLE_B = 8'h40;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_GUESS_A = 3'b001,
        ST_GUESS_B = 3'b010,
        ST_STEP_A = 3'b011,
        ST_STEP_B = 3'b100,
        ST_ZERO_OUT = 3'b101
    } phase_state_t;
endpackage

/* File: hw/servo_tick_gen.sv */
`timescale 1ns/1ps
module servo_tick_gen #(
    parameter int unsigned DIV = phasing_pkg::SERVO_DIV
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    output logic tick_o
);
    import phasing_pkg::*;

    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } tick_state_t;

    tick_state_t s_reg;
    tick_state_t s_next;

    // ==========================================================
    // Divider: one-cycle servo enable every DIV clocks
    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (s_reg.cnt == 16'(DIV - 1)) begin
            s_next.cnt = 16'h0000;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick_o = s_reg.tick;
endmodule // servo_tick_gen

/* File: hw/phase_vector_mixer.sv */
`timescale 1ns/1ps
module phase_vector_mixer (
    input wire logic signed [15:0] magnitude_i,
    input wire logic [7:0] angle_i,
    input wire logic [7:0] phase_angle_setting_i,
    output logic signed [15:0] out_a_o,
    output logic signed [15:0] out_b_o
);
    import phasing_pkg::*;

    // ==========================================================
    // Coarse sine, 16 steps per cycle, scaled by 127
    // Coarse on purpose: a guess only needs the rough direction.
    function automatic logic signed [7:0] coarse_sin(input logic [7:0] ang);
        logic signed [7:0] tbl [0:15];
        tbl = '{8'sh00, 8'sh31, 8'sh5a, 8'sh75, 8'sh7f, 8'sh75, 8'sh5a, 8'sh31,
                8'sh00, -8'sh31, -8'sh5a, -8'sh75, -8'sh7f, -8'sh75, -8'sh5a,
                -8'sh31};
        return tbl[ang[7:4]];
    endfunction

    function automatic logic signed [15:0] scale(input logic signed [15:0] mag,
                                                 input logic signed [7:0] s);
        logic signed [23:0] prod;
        prod = mag * s;
        return prod[22:7];
    endfunction

    // Vector spread over two phases at the guessed angle
    always_comb begin
        out_a_o = scale(magnitude_i, coarse_sin(angle_i));
        out_b_o = scale(magnitude_i, coarse_sin(angle_i + phase_angle_setting_i));
    end
endmodule // phase_vector_mixer

/* File: hw/motor_phasing.sv */
// What this block does
// - Search magnitude is signed 16-bit, in DAC units, driven as open-loop output.
// - Search runs only when commutated here, synchronous, and no absolute sensor.
// - Mode 1 or 3 searches at power-on; mode 0 or 2 waits for start.
// - Mode 0 or 1: two-guess search spreads magnitude vector by guessed angle.
// - Mode 2 or 3: stepper search forces magnitude current into single phases.
// - Two-guess holds each guessed angle for duration servo cycles.
// - Stepper holds each phase for duration times 256 servo cycles.
// - Offset is signed 24-bit, counts times commutation cycle count.
// - With absolute sensor: reference at power-on if mode 1, and every start.
// - Reference load copies the offset straight into phase position.
// - Magnitude and duration both zero means no search motion; both reset zero.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module motor_phasing #(
    parameter int unsigned SERVO_DIV = phasing_pkg::SERVO_DIV
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [23:0] enc_pos_i,
    input wire logic [23:0] abs_pos_i,
    input wire logic [7:0] phase_angle_setting_i,
    output logic signed [15:0] dac_a_o,
    output logic signed [15:0] dac_b_o,
    output logic [23:0] phase_pos_o,
    output logic open_loop_o,
    output logic phased_o
);
    import phasing_pkg::*;

    typedef struct packed {
        phase_state_t state;
        logic [15:0] cnt;
        logic [23:0] start_pos;
        logic d1_pos;
        logic [23:0] phase_pos;
        logic power_pending;
        logic phased;
        logic skipped;
        logic signed [15:0] dac_a;
        logic signed [15:0] dac_b;
        logic [15:0] magnitude;
        logic [7:0] duration;
        logic [23:0] offset;
        logic [31:0] config_bits;
        logic [31:0] rdata;
    } phasing_state_t;

    phasing_state_t s_reg;
    phasing_state_t s_next;

    logic servo_tick;
    logic signed [15:0] mix_a;
    logic signed [15:0] mix_b;
    logic [7:0] mix_angle;

    // Config fields, named for readability
    logic commutate;
    logic slip;
    logic [1:0] mode;
    logic [7:0] sensor_ptr;
    logic [7:0] cycle_count;
    logic stepper;
    logic search_ok;
    logic abs_ok;
    logic [15:0] hold_target;
    logic hold_done;
    logic [23:0] delta;
    logic [7:0] est_angle;
    logic [31:0] abs_scaled;
    logic wr_cmd;
    logic start_req;
    logic auto_req;

    // ==========================================================
    // Servo-cycle enable
    servo_tick_gen #(
        .DIV(SERVO_DIV)
    ) u_tick (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .tick_o(servo_tick)
    );

    // ==========================================================
    // Two-guess vector output
    assign mix_angle = (s_reg.state == ST_GUESS_B) ? GUESS_ANGLE_B : GUESS_ANGLE_A;

    phase_vector_mixer u_mix (
        .magnitude_i(s_reg.magnitude),
        .angle_i(mix_angle),
        .phase_angle_setting_i(phase_angle_setting_i),
        .out_a_o(mix_a),
        .out_b_o(mix_b)
    );

    // ==========================================================
    // Decoded settings and helpers
    always_comb begin
        commutate = s_reg.config_bits[CFG_COMMUTATE];
        slip = s_reg.config_bits[CFG_SLIP];
        mode = s_reg.config_bits[CFG_MODE_LO +: 2];
        sensor_ptr = s_reg.config_bits[CFG_PTR_LO +: 8];
        cycle_count = s_reg.config_bits[CFG_CCC_LO +: 8];
        stepper = mode[1];
        search_ok = commutate && !slip && (sensor_ptr == 8'h00);
        abs_ok = commutate && (sensor_ptr != 8'h00);
        // Hold time in servo cycles per method
        hold_target = stepper ? 16'(s_reg.duration * STEP_TIME_SCALE)
                              : {8'h00, s_reg.duration};
        hold_done = (s_reg.cnt == hold_target);
        delta = enc_pos_i - s_reg.start_pos;
        // Rough rotor angle from the direction of the two responses
        case ({s_reg.d1_pos, !delta[23]})
            2'b11: est_angle = 8'h20;
            2'b01: est_angle = 8'h60;
            2'b00: est_angle = 8'ha0;
            default: est_angle = 8'he0;
        endcase
        // Absolute reading scaled into phase units plus signed offset
        abs_scaled = 32'($signed(abs_pos_i) * $signed({1'b0, cycle_count}))
                   + 32'($signed(s_reg.offset));
        wr_cmd = wr_i && (addr_i == OFS_COMMAND);
        start_req = wr_cmd && wdata_i[CMD_PHASE_START];
        // Power-on run, taken once software marks setup complete
        auto_req = wr_cmd && wdata_i[CMD_INIT_DONE] && s_reg.power_pending;
    end

    // ==========================================================
    // Next-state logic: registers, sequencer and read port
    always_comb begin
        s_next = s_reg;

        // Register writes; settings are frozen while a search runs
        if (wr_i && s_reg.state == ST_IDLE) begin
            if (addr_i == OFS_MAGNITUDE) begin
                s_next.magnitude = wdata_i[15:0];
            end else if (addr_i == OFS_DURATION) begin
                s_next.duration = wdata_i[7:0];
            end else if (addr_i == OFS_OFFSET) begin
                s_next.offset = wdata_i[23:0];
            end else if (addr_i == OFS_CONFIG) begin
                s_next.config_bits = wdata_i;
            end
        end
        if (auto_req) begin
            s_next.power_pending = 1'b0;
        end

        // Hold counter runs on servo enables only
        if (s_reg.state != ST_IDLE && servo_tick) begin
            s_next.cnt = s_reg.cnt + 16'h0001;
        end

        case (s_reg.state)
            ST_IDLE: begin
                s_next.cnt = 16'h0000;
                s_next.dac_a = 16'sh0000;
                s_next.dac_b = 16'sh0000;
                if (wr_cmd && wdata_i[CMD_REF_LOAD]) begin
                    s_next.phase_pos = s_reg.offset;
                end else if ((start_req || (auto_req && mode == 2'b01)) && abs_ok) begin
                    s_next.phase_pos = abs_scaled[23:0];
                    s_next.phased = 1'b1;
                end else if ((start_req || (auto_req && mode[0])) && search_ok) begin
                    s_next.phased = 1'b0;
                    s_next.skipped = 1'b0;
                    s_next.start_pos = enc_pos_i;
                    if (s_reg.magnitude == 16'h0000 && s_reg.duration == 8'h00) begin
                        s_next.skipped = 1'b1;
                    end else if (stepper) begin
                        s_next.state = ST_STEP_A;
                    end else begin
                        s_next.state = ST_GUESS_A;
                    end
                end
            end
            ST_GUESS_A: begin
                s_next.dac_a = mix_a;
                s_next.dac_b = mix_b;
                if (hold_done) begin
                    // Sample first response, start second guess
                    s_next.d1_pos = !delta[23];
                    s_next.start_pos = enc_pos_i;
                    s_next.cnt = 16'h0000;
                    s_next.state = ST_GUESS_B;
                end
            end
            ST_GUESS_B: begin
                s_next.dac_a = mix_a;
                s_next.dac_b = mix_b;
                if (hold_done) begin
                    s_next.phase_pos = {est_angle, 16'h0000};
                    s_next.cnt = 16'h0000;
                    s_next.state = ST_ZERO_OUT;
                end
            end
            ST_STEP_A: begin
                // Current into A, opposite into B
                s_next.dac_a = s_reg.magnitude;
                s_next.dac_b = -s_reg.magnitude;
                if (hold_done) begin
                    s_next.cnt = 16'h0000;
                    s_next.state = ST_STEP_B;
                end
            end
            ST_STEP_B: begin
                // A released: rotor settles at cycle zero
                s_next.dac_a = 16'sh0000;
                s_next.dac_b = -s_reg.magnitude;
                if (hold_done) begin
                    s_next.phase_pos = 24'h000000;
                    s_next.cnt = 16'h0000;
                    s_next.state = ST_ZERO_OUT;
                end
            end
            ST_ZERO_OUT: begin
                // One more open-loop cycle; outputs read zero as the loop closes
                s_next.dac_a = 16'sh0000;
                s_next.dac_b = 16'sh0000;
                s_next.phased = 1'b1;
                s_next.state = ST_IDLE;
            end
            default: begin
                s_next.state = ST_IDLE;
            end
        endcase

        // Read data valid in the cycle after the strobe only
        s_next.rdata = 32'h00000000;
        if (rd_i) begin
            if (addr_i == OFS_MAGNITUDE) begin
                s_next.rdata = {16'h0000, s_reg.magnitude};
            end else if (addr_i == OFS_DURATION) begin
                s_next.rdata = {24'h000000, s_reg.duration};
            end else if (addr_i == OFS_OFFSET) begin
                s_next.rdata = {8'h00, s_reg.offset};
            end else if (addr_i == OFS_CONFIG) begin
                s_next.rdata = s_reg.config_bits;
            end else if (addr_i == OFS_STATUS) begin
                s_next.rdata = {24'h000000, s_reg.power_pending, s_reg.skipped,
                                s_reg.phased, 2'b00, s_reg.state};
            end else if (addr_i == OFS_PHASE_POS) begin
                s_next.rdata = {8'h00, s_reg.phase_pos};
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg <= '0;
            s_reg.state <= ST_IDLE;
            s_reg.power_pending <= 1'b1;
            s_reg.magnitude <= RST_MAGNITUDE;
            s_reg.duration <= RST_DURATION;
            s_reg.offset <= RST_OFFSET;
            s_reg.config_bits <= RST_CONFIG;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // Outputs from flops, except open_loop_o decoded from the state register
    assign rdata_o = s_reg.rdata;
    assign dac_a_o = s_reg.dac_a;
    assign dac_b_o = s_reg.dac_b;
    assign phase_pos_o = s_reg.phase_pos;
    assign open_loop_o = (s_reg.state != ST_IDLE);
    assign phased_o = s_reg.phased;
endmodule // motor_phasing

/* File: test/motor_phasing_checker.sv */
`timescale 1ns/1ps
module motor_phasing_checker import phasing_pkg::*; #(
    parameter int unsigned SERVO_DIV = 4
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic signed [15:0] dac_a_o,
    input wire logic signed [15:0] dac_b_o,
    input wire logic [23:0] phase_pos_o,
    input wire logic open_loop_o,
    input wire logic phased_o
);
    // ==========================================
    // Shadow of the settings, only taken while idle
    logic [15:0] mag_q;
    logic [7:0] dur_q;
    logic [23:0] off_q;
    logic cmd_w;
    assign cmd_w = wr_i && addr_i == OFS_COMMAND && !open_loop_o;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mag_q <= 16'h0000;
            dur_q <= 8'h00;
            off_q <= 24'h000000;
        end else if (wr_i && !open_loop_o) begin
            if (addr_i == OFS_MAGNITUDE) mag_q <= wdata_i[15:0];
            if (addr_i == OFS_DURATION) dur_q <= wdata_i[7:0];
            if (addr_i == OFS_OFFSET) off_q <= wdata_i[23:0];
        end
    end
    // ==========================================
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    a_mag_readback: assert property (rd_i && addr_i == OFS_MAGNITUDE |=>
        rdata_o == {16'h0000, mag_q}) else $error("magnitude readback wrong");
    a_dur_readback: assert property (rd_i && addr_i == OFS_DURATION |=>
        rdata_o == {24'h000000, dur_q}) else $error("duration readback wrong");
    a_off_readback: assert property (rd_i && addr_i == OFS_OFFSET |=>
        rdata_o == {8'h00, off_q}) else $error("offset readback wrong");
    a_ref_load_copy: assert property (cmd_w && wdata_i[CMD_REF_LOAD] |=>
        ##[0:1] phase_pos_o == off_q) else $error("offset not loaded");
    a_zero_no_move: assert property (cmd_w && mag_q == 0 && dur_q == 0 |=>
        !open_loop_o [*2]) else $error("search ran with zero settings");
    a_search_min_len: assert property ($rose(open_loop_o) |->
        open_loop_o [*3]) else $error("search too short");
    a_close_phased: assert property ($fell(open_loop_o) |-> phased_o &&
        dac_a_o == 0 && dac_b_o == 0) else $error("loop closed badly");
    a_idle_dac_zero: assert property (!open_loop_o && !$past(open_loop_o) |->
        dac_a_o == 0 && dac_b_o == 0) else $error("output while idle");
    a_cmd_reads_zero: assert property (rd_i && addr_i == OFS_COMMAND |=>
        rdata_o == 0) else $error("command register readable");
endmodule // motor_phasing_checker

bind motor_phasing motor_phasing_checker #(.SERVO_DIV(SERVO_DIV)) u_motor_phasing_checker (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dac_a_o(dac_a_o),
    .dac_b_o(dac_b_o), .phase_pos_o(phase_pos_o), .open_loop_o(open_loop_o),
    .phased_o(phased_o));

/* File: test/amp_sensor_model.sv */
`timescale 1ns/1ps
module amp_sensor_model #(
    parameter logic [23:0] ABS_POS = 24'h000100
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic signed [15:0] dac_a_i,
    input wire logic signed [15:0] dac_b_i,
    output logic [23:0] enc_pos_o,
    output logic [23:0] abs_pos_o,
    output logic [7:0] angle_o
);
    typedef struct packed {logic [23:0] enc;} model_state_t;
    model_state_t st_reg;
    model_state_t st_next;
    // Crude rotor: drifts with the sign of the net phase drive
    always_comb begin
        st_next = st_reg;
        if (dac_a_i + dac_b_i > 0) st_next.enc = st_reg.enc + 24'h000001;
        if (dac_a_i + dac_b_i < 0) st_next.enc = st_reg.enc - 24'h000001;
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) st_reg <= '0;
        else st_reg <= st_next;
    end
    assign enc_pos_o = st_reg.enc;
    assign abs_pos_o = ABS_POS;
    // Below 128, so positive search magnitudes are correct here
    assign angle_o = 8'h55;
endmodule // amp_sensor_model

/* File: test/test_motor_phasing.sv */
`timescale 1ns/1ps
module test_motor_phasing;
    import phasing_pkg::*;
    localparam int S = 4;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h00000000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic [23:0] enc_pos, abs_pos, phase_pos_o;
    logic [7:0] angle;
    logic signed [15:0] dac_a_o, dac_b_o;
    logic open_loop_o, phased_o;
    int error_cnt = 0;
    int comparisons = 0;
    int n;
    logic [31:0] r;
    always #25 clk_i = ~clk_i;
    motor_phasing #(.SERVO_DIV(S)) u_motor_phasing (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .enc_pos_i(enc_pos), .abs_pos_i(abs_pos), .phase_angle_setting_i(angle),
        .dac_a_o(dac_a_o), .dac_b_o(dac_b_o), .phase_pos_o(phase_pos_o),
        .open_loop_o(open_loop_o), .phased_o(phased_o));
    amp_sensor_model u_amp_sensor_model (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .dac_a_i(dac_a_o), .dac_b_i(dac_b_o), .enc_pos_o(enc_pos),
        .abs_pos_o(abs_pos), .angle_o(angle));
    // ==========================================
    // Bus and check tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s exp %h saw %h", nm, e, s);
        end
    endtask
    // Read data only stand in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        r = rdata_o;
        chk($sformatf("reg %h", a), r, e);
    endtask
    task automatic wait_ol(input logic v);
        n = 0;
        while (open_loop_o !== v && n < 5000) begin
            @(negedge clk_i);
            n++;
        end
        chk("open_loop", 32'(open_loop_o), 32'(v));
    endtask
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Longest path is two stepper phases; far more than that means a hang
    // Acts as the bench's loose kill limit, 40000 clocks, on a runaway search
    initial begin
        #(50 * 40000);
        error_cnt++;
        wrap_up();
    end
    // ==========================================
    // Scenarios
    initial begin
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        rchk(OFS_MAGNITUDE, 32'h0);
        rchk(OFS_DURATION, 32'h0);
        rchk(OFS_OFFSET, 32'h0);
        rchk(OFS_CONFIG, RST_CONFIG);
        rchk(OFS_STATUS, 32'h00000080);
        rchk(OFS_COMMAND, 32'h0);
        rchk(8'h1c, 32'h0);
        // Extremes of each field
        wr(OFS_MAGNITUDE, 32'h00008000);
        rchk(OFS_MAGNITUDE, 32'h00008000);
        wr(OFS_DURATION, 32'h000000ff);
        rchk(OFS_DURATION, 32'h000000ff);
        wr(OFS_OFFSET, 32'h00800000);
        rchk(OFS_OFFSET, 32'h00800000);
        // Both zero: start is accepted but nothing moves
        wr(OFS_MAGNITUDE, 32'h0);
        wr(OFS_DURATION, 32'h0);
        wr(OFS_CONFIG, 32'h00010001);
        wr(OFS_COMMAND, 32'h1);
        repeat (3) @(negedge clk_i);
        chk("no motion", 32'(open_loop_o), 32'h0);
        rchk(OFS_STATUS, 32'h000000c0);
        // Not commutated here, then slip motor: start refused
        wr(OFS_MAGNITUDE, 32'h00000100);
        wr(OFS_DURATION, 32'h1);
        for (int i = 0; i < 2; i++) begin
            wr(OFS_CONFIG, i == 0 ? 32'h00010000 : 32'h00010003);
            wr(OFS_COMMAND, 32'h1);
            repeat (3) @(negedge clk_i);
            chk("refused", 32'(open_loop_o), 32'h0);
        end
        // Direct offset load
        wr(OFS_OFFSET, 32'h00123456);
        wr(OFS_COMMAND, 32'h2);
        repeat (2) @(negedge clk_i);
        chk("ref load", 32'(phase_pos_o), 32'h00123456);
        rchk(OFS_PHASE_POS, 32'h00123456);
        // Absolute sensor, cycle count 2: 0x100 * 2 + 0x10
        wr(OFS_OFFSET, 32'h00000010);
        wr(OFS_CONFIG, 32'h00020101);
        wr(OFS_COMMAND, 32'h1);
        repeat (2) @(negedge clk_i);
        chk("abs ref", 32'(phase_pos_o), 32'h00000210);
        chk("abs phased", 32'({phased_o, open_loop_o}), 32'h2);
        // Power-on stepper search through init-done
        wr(OFS_CONFIG, 32'h0001000d);
        wr(OFS_COMMAND, 32'h4);
        wait_ol(1'b1);
        repeat (2) @(negedge clk_i);
        chk("step dacs", {dac_a_o, dac_b_o}, 32'h0100ff00);
        n = 0;
        while (dac_a_o !== 16'sh0000 && n < 2000) begin
            @(negedge clk_i);
            n++;
        end
        chk("step hold", 32'(n >= 256 * S - 10 && n <= 256 * S + 6), 32'h1);
        wait_ol(1'b0);
        chk("step end", 32'({phased_o, phase_pos_o}), 32'h01000000);
        wr(OFS_COMMAND, 32'h4);
        repeat (3) @(negedge clk_i);
        chk("init once", 32'(open_loop_o), 32'h0);
        // Two-guess search on start, three servo cycles per guess
        wr(OFS_DURATION, 32'h3);
        wr(OFS_MAGNITUDE, 32'h00000400);
        wr(OFS_CONFIG, 32'h00010001);
        wr(OFS_COMMAND, 32'h1);
        wait_ol(1'b1);
        repeat (2) @(negedge clk_i);
        chk("guess out", 32'(dac_a_o != 0 || dac_b_o != 0), 32'h1);
        wait_ol(1'b0);
        chk("guess hold", 32'(n >= 2 * 2 * S - 4 && n <= 2 * 3 * S + 4), 32'h1);
        chk("guess pos", 32'(phase_pos_o & 24'h3fffff), 32'h00200000);
        wrap_up();
    end
endmodule // test_motor_phasing
